// ---- core/msurb_pkg.sv ----
package msurb_pkg;
   // register addresses, seven bits after the direction bit
   localparam logic [6:0] ADDR_MIN_PIXEL = 7'h0a;
   localparam logic [6:0] ADDR_PIXEL_CAPTURE = 7'h0b;
   localparam logic [6:0] ADDR_SENSOR_CONTROL = 7'h0d;
   localparam logic [6:0] ADDR_SOFT_RESET = 7'h3a;
   localparam logic [6:0] ADDR_INV_REV = 7'h3f;
   localparam logic [6:0] ADDR_LED_DRIVE = 7'h40;
   localparam logic [6:0] ADDR_REST_MODE = 7'h45;
   localparam logic [6:0] ADDR_BURST = 7'h63;

   localparam logic [7:0] SOFT_RESET_KEY = 8'h5a;

   // field positions
   localparam int SPI_WRITE_BIT = 7;
   localparam int CTRL_PD_BIT = 1;
   localparam int CTRL_RES_BIT = 0;
   localparam int LED_LDC_BIT = 0;
   localparam int REST_FIELD_LSB = 6;
   localparam int PIX_VALID_BIT = 7;

   // reset values
   localparam logic CTRL_PD_RESET = 1'b0;
   localparam logic CTRL_RES_RESET = 1'b0;
   localparam logic LED_LDC_RESET = 1'b0;
   localparam logic [1:0] REST_RESET = 2'h0;
   localparam logic [2:0] PIN_SYNC_RESET = 3'h6;

   // counts
   localparam logic [7:0] PIXEL_LAST = 8'he0;
   localparam logic [2:0] BURST_LAST = 3'h6;
   localparam logic [2:0] BIT_LAST = 3'h7;

   typedef enum logic [1:0] {
      ST_ADDR,
      ST_DATA_IN,
      ST_DATA_OUT
   } msurb_state_t;
endpackage

// ---- core/msurb_stream_if.sv ----
`timescale 1ns/1ps
interface msurb_stream_if #(parameter int WIDTH = 8);
   logic [WIDTH-1:0] data;
   logic valid;
   logic ready;
   modport source(output data, output valid, input ready);
   modport sink(input data, input valid, output ready);
endinterface

// ---- core/msurb_sync.sv ----
`timescale 1ns/1ps
module msurb_sync #(
   parameter int W = 3,
   parameter logic [W-1:0] RESET_VAL = '0
)(
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);
   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;
   logic [W-1:0] out_reg;
   // a bit only changes once stages two and three agree on it
   wire [W-1:0] out_next = (s2_reg & s3_reg) | (out_reg & (s2_reg | s3_reg));

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_reset_n)
      begin
         s1_reg <= RESET_VAL;
         s2_reg <= RESET_VAL;
         s3_reg <= RESET_VAL;
         out_reg <= RESET_VAL;
      end
      else
      begin
         s1_reg <= i_async;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         out_reg <= out_next;
      end
   end

   assign o_sync = out_reg;
endmodule

// ---- core/msurb_fifo.sv ----
`timescale 1ns/1ps
module msurb_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
)(
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   input wire logic i_flush,
   msurb_stream_if.sink s_in,
   msurb_stream_if.source s_out
);
   // depth must be a power of two for the wrap bit to work
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW:0] wr_ptr_reg;
   logic [AW:0] rd_ptr_reg;

   wire full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
      (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
   wire empty = (wr_ptr_reg == rd_ptr_reg);
   wire push = s_in.valid & ~full;
   wire pop = s_out.ready & ~empty;

   assign s_in.ready = ~full;
   assign s_out.valid = ~empty;
   assign s_out.data = mem_reg[rd_ptr_reg[AW-1:0]];

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_reset_n || i_flush)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end
      else
      begin
         if (push)
            wr_ptr_reg <= wr_ptr_reg + (AW+1)'(1);
         if (pop)
            rd_ptr_reg <= rd_ptr_reg + (AW+1)'(1);
      end
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (push)
         mem_reg[wr_ptr_reg[AW-1:0]] <= s_in.data;
   end
endmodule

// ---- core/msurb_top.sv ----
`timescale 1ns/1ps
module msurb_top
   import msurb_pkg::*;
#(
   parameter logic [7:0] REVISION_ID = 8'h3c, // arbitrary value
   parameter int FIFO_DEPTH = 16
)(
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   input wire logic i_sclk,
   input wire logic i_chip_select_n,
   input wire logic i_mosi,
   output logic o_miso,
   output logic o_miso_oe,
   input wire logic i_frame_start,
   input wire logic [6:0] i_pixel_data,
   output logic [7:0] o_pixel_index,
   input wire logic [7:0] i_delta_x,
   input wire logic [7:0] i_delta_y,
   input wire logic [7:0] i_squal,
   input wire logic [15:0] i_shutter,
   input wire logic [7:0] i_max_pixel,
   input wire logic [7:0] i_pixel_sum,
   input wire logic [7:0] i_min_pixel,
   input wire logic [1:0] i_rest_mode_status,
   output logic o_power_down,
   output logic o_resolution_select,
   output logic o_led_current_select,
   output logic [1:0] o_rest_mode_field,
   output logic o_rest_force_strobe,
   output logic o_chip_reset,
   output logic o_burst_active
);
   // soft reset acts one cycle after the key byte lands
   logic soft_rst_reg;
   wire rst_n = i_reset_n & ~soft_rst_reg;

   // pins: sclk, chip select, mosi through the three-stage filter
   logic [2:0] pins_s;
   msurb_sync #(.W(3), .RESET_VAL(PIN_SYNC_RESET)) u_pin_sync (
      .i_clk_sys(i_clk_sys),
      .i_reset_n(i_reset_n),
      .i_async({i_sclk, i_chip_select_n, i_mosi}),
      .o_sync(pins_s)
   );
   wire sclk_s = pins_s[2];
   wire ncs_s = pins_s[1];
   wire mosi_s = pins_s[0];

   msurb_stream_if #(.WIDTH(8)) push_if ();
   msurb_stream_if #(.WIDTH(8)) pop_if ();

   // read bytes queue here so a slow master back-pressures the burst feeder
   msurb_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rd_fifo (
      .i_clk_sys(i_clk_sys),
      .i_reset_n(rst_n),
      .i_flush(ncs_s),
      .s_in(push_if),
      .s_out(pop_if)
   );

   msurb_state_t state_reg;
   msurb_state_t state_next;
   logic sclk_q_reg;
   logic [2:0] bit_cnt_reg;
   logic [7:0] shift_in_reg;
   logic [6:0] addr_reg;
   logic [7:0] tx_reg;
   logic miso_reg;
   logic rd_pend_reg;
   logic burst_reg;
   logic [2:0] burst_cnt_reg;
   logic [7:0] pix_index_reg;
   logic pix_valid_reg;
   logic [6:0] pix_data_reg;
   logic pd_reg;
   logic res_reg;
   logic ldc_reg;
   logic [1:0] rest_reg;
   logic rest_strobe_reg;

   // serial edge detection, ignored while deselected
   wire sclk_rise = ~ncs_s & sclk_s & ~sclk_q_reg;
   wire sclk_fall = ~ncs_s & ~sclk_s & sclk_q_reg;
   wire byte_done = sclk_rise & (bit_cnt_reg == BIT_LAST);
   wire [7:0] rx_byte = {shift_in_reg[6:0], mosi_s};
   wire addr_done = (state_reg == ST_ADDR) & byte_done;
   wire rd_start = addr_done & ~rx_byte[SPI_WRITE_BIT];
   wire burst_start = rd_start & (rx_byte[6:0] == ADDR_BURST);
   wire wr_fire = (state_reg == ST_DATA_IN) & byte_done;

   // write decode
   wire wr_pix = wr_fire & (addr_reg == ADDR_PIXEL_CAPTURE);
   wire wr_ctrl = wr_fire & (addr_reg == ADDR_SENSOR_CONTROL);
   wire wr_led = wr_fire & (addr_reg == ADDR_LED_DRIVE);
   wire wr_rest = wr_fire & (addr_reg == ADDR_REST_MODE);
   wire wr_soft = wr_fire & (addr_reg == ADDR_SOFT_RESET) & (rx_byte == SOFT_RESET_KEY);

   // read side
   // every source is an argument so the assigns below re-evaluate on any change
   function automatic logic [7:0] read_value(input logic [6:0] a, input logic [7:0] pix,
      input logic [1:0] ctrl, input logic [7:0] minp, input logic [1:0] rest);
      logic [7:0] v;
      v = 8'h00;
      case (a)
         ADDR_MIN_PIXEL: v = minp;
         ADDR_PIXEL_CAPTURE: v = pix;
         ADDR_SENSOR_CONTROL: v = {6'h00, ctrl};
         ADDR_INV_REV: v = ~REVISION_ID;
         ADDR_REST_MODE: v = {rest, 6'h00};
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   function automatic logic [7:0] burst_byte(input logic [2:0] n, input logic [55:0] src);
      logic [7:0] v;
      v = src[7:0];
      case (n)
         3'h0: v = src[55:48];
         3'h1: v = src[47:40];
         3'h2: v = src[39:32];
         3'h3: v = src[31:24];
         3'h4: v = src[23:16];
         3'h5: v = src[15:8];
         default: v = src[7:0];
      endcase
      return v;
   endfunction

   wire [55:0] burst_src = {i_delta_x, i_delta_y, i_squal, i_shutter, i_max_pixel, i_pixel_sum};
   wire [7:0] rd_byte = read_value(addr_reg, {pix_valid_reg, pix_data_reg}, {pd_reg, res_reg},
      i_min_pixel, i_rest_mode_status);

   wire addr_mapped = (addr_reg == ADDR_MIN_PIXEL) | (addr_reg == ADDR_PIXEL_CAPTURE) |
      (addr_reg == ADDR_SENSOR_CONTROL) | (addr_reg == ADDR_INV_REV) |
      (addr_reg == ADDR_REST_MODE);
   assign push_if.valid = burst_reg | rd_pend_reg;
   assign push_if.data = burst_reg ? burst_byte(burst_cnt_reg, burst_src) : rd_byte;
   wire push_fire = push_if.valid & push_if.ready;
   wire pix_read_take = push_fire & ~burst_reg & (addr_reg == ADDR_PIXEL_CAPTURE);

   // a byte is pulled only at the first falling edge of each data byte
   wire tx_load = sclk_fall & (state_reg == ST_DATA_OUT) & (bit_cnt_reg == 3'h0);
   assign pop_if.ready = tx_load;
   wire [7:0] tx_byte = pop_if.valid ? pop_if.data : 8'h00;

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         ST_ADDR:
            if (byte_done)
               state_next = rx_byte[SPI_WRITE_BIT] ? ST_DATA_IN : ST_DATA_OUT;
         ST_DATA_IN:
            if (byte_done)
               state_next = ST_ADDR;
         ST_DATA_OUT:
            if (byte_done && !burst_reg)
               state_next = ST_ADDR;
         default: state_next = ST_ADDR;
      endcase
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_reset_n)
         soft_rst_reg <= 1'b0;
      else
         soft_rst_reg <= wr_soft;
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (!rst_n)
         sclk_q_reg <= 1'b1;
      else
         sclk_q_reg <= sclk_s;
   end

   // serial framing; chip select high drops everything back to address
   always_ff @(posedge i_clk_sys)
   begin
      if (!rst_n || ncs_s)
      begin
         state_reg <= ST_ADDR;
         bit_cnt_reg <= 3'h0;
         shift_in_reg <= 8'h00;
      end
      else
      begin
         state_reg <= state_next;
         if (sclk_rise)
         begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            shift_in_reg <= rx_byte;
         end
      end
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (!rst_n)
         addr_reg <= 7'h00;
      else if (addr_done)
         addr_reg <= rx_byte[6:0];
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (!rst_n)
      begin
         tx_reg <= 8'h00;
         miso_reg <= 1'b0;
      end
      else if (tx_load)
      begin
         tx_reg <= {tx_byte[6:0], 1'b0};
         miso_reg <= tx_byte[7];
      end
      else if (sclk_fall && state_reg == ST_DATA_OUT)
      begin
         tx_reg <= {tx_reg[6:0], 1'b0};
         miso_reg <= tx_reg[7];
      end
   end

   // single reads and burst feeding
   always_ff @(posedge i_clk_sys)
   begin
      if (!rst_n || ncs_s)
      begin
         rd_pend_reg <= 1'b0;
         burst_reg <= 1'b0;
         burst_cnt_reg <= 3'h0;
      end
      else if (burst_start)
      begin
         burst_reg <= 1'b1;
         burst_cnt_reg <= 3'h0;
      end
      else if (rd_start)
         rd_pend_reg <= 1'b1;
      else if (push_fire && burst_reg)
         burst_cnt_reg <= (burst_cnt_reg == BURST_LAST) ? BURST_LAST : burst_cnt_reg + 3'h1;
      else if (push_fire)
         rd_pend_reg <= 1'b0;
   end

   // pixel grabber; a clear valid flag means armed
   always_ff @(posedge i_clk_sys)
   begin
      if (!rst_n)
      begin
         pix_index_reg <= 8'h00;
         pix_valid_reg <= 1'b0;
         pix_data_reg <= 7'h00;
      end
      else if (wr_pix)
      begin
         pix_index_reg <= 8'h00;
         pix_valid_reg <= 1'b0;
      end
      else if (pix_read_take && pix_valid_reg)
      begin
         pix_index_reg <= (pix_index_reg == PIXEL_LAST) ? 8'h00 : pix_index_reg + 8'h01;
         pix_valid_reg <= 1'b0;
      end
      else if (i_frame_start && !pix_valid_reg)
      begin
         pix_data_reg <= i_pixel_data;
         pix_valid_reg <= 1'b1;
      end
   end

   // control bits; reserved bits of each write are dropped
   always_ff @(posedge i_clk_sys)
   begin
      if (!rst_n)
      begin
         pd_reg <= CTRL_PD_RESET;
         res_reg <= CTRL_RES_RESET;
         ldc_reg <= LED_LDC_RESET;
         rest_reg <= REST_RESET;
         rest_strobe_reg <= 1'b0;
      end
      else
      begin
         rest_strobe_reg <= wr_rest;
         if (wr_ctrl)
         begin
            pd_reg <= rx_byte[CTRL_PD_BIT];
            res_reg <= rx_byte[CTRL_RES_BIT];
         end
         if (wr_led)
            ldc_reg <= rx_byte[LED_LDC_BIT];
         if (wr_rest)
            rest_reg <= rx_byte[REST_FIELD_LSB+1:REST_FIELD_LSB];
      end
   end

   assign o_miso = miso_reg;
   assign o_miso_oe = ~ncs_s;
   assign o_pixel_index = pix_index_reg;
   assign o_power_down = pd_reg;
   assign o_resolution_select = res_reg;
   assign o_led_current_select = ldc_reg;
   assign o_rest_mode_field = rest_reg;
   assign o_rest_force_strobe = rest_strobe_reg;
   assign o_chip_reset = soft_rst_reg;
   assign o_burst_active = burst_reg;

   property p_capture_holds;
      @(posedge i_clk_sys) disable iff (!rst_n)
      pix_valid_reg && !pix_read_take && !wr_pix |=> pix_valid_reg && $stable(pix_data_reg);
   endproperty
   a_capture_holds: assert property (p_capture_holds) else $error("captured pixel changed");

   property p_read_advances;
      @(posedge i_clk_sys) disable iff (!rst_n)
      pix_read_take && pix_valid_reg && !wr_pix && pix_index_reg != PIXEL_LAST
      |=> !pix_valid_reg && pix_index_reg == $past(pix_index_reg) + 8'h01;
   endproperty
   a_read_advances: assert property (p_read_advances) else $error("pixel index not advanced");

   property p_valid_bit;
      @(posedge i_clk_sys) disable iff (!rst_n)
      pix_read_take |-> push_if.data[PIX_VALID_BIT] == pix_valid_reg;
   endproperty
   a_valid_bit: assert property (p_valid_bit) else $error("pixel valid flag wrong");

   property p_write_rearm;
      @(posedge i_clk_sys) disable iff (!rst_n)
      wr_pix |=> pix_index_reg == 8'h00 && !pix_valid_reg;
   endproperty
   a_write_rearm: assert property (p_write_rearm) else $error("pixel write did not re-arm");

   property p_index_range;
      @(posedge i_clk_sys) disable iff (!rst_n)
      pix_index_reg <= PIXEL_LAST;
   endproperty
   a_index_range: assert property (p_index_range) else $error("pixel index out of range");

   property p_ctrl_write;
      @(posedge i_clk_sys) disable iff (!rst_n)
      wr_ctrl |=> o_power_down == $past(rx_byte[1]) && o_resolution_select == $past(rx_byte[0]);
   endproperty
   a_ctrl_write: assert property (p_ctrl_write) else $error("control bits not stored");

   property p_inv_rev;
      @(posedge i_clk_sys) disable iff (!rst_n)
      push_fire && !burst_reg && addr_reg == ADDR_INV_REV |-> push_if.data == ~REVISION_ID;
   endproperty
   a_inv_rev: assert property (p_inv_rev) else $error("inverted revision wrong");

   property p_rest_force;
      @(posedge i_clk_sys) disable iff (!rst_n)
      wr_rest |=> o_rest_force_strobe && o_rest_mode_field == $past(rx_byte[7:6]) ##1 !o_rest_force_strobe;
   endproperty
   a_rest_force: assert property (p_rest_force) else $error("rest mode force wrong");

   property p_burst_start;
      @(posedge i_clk_sys) disable iff (!rst_n)
      burst_start && !ncs_s |=> burst_reg && burst_cnt_reg == 3'h0 && state_reg == ST_DATA_OUT;
   endproperty
   a_burst_start: assert property (p_burst_start) else $error("burst did not start");

   property p_burst_sticks;
      @(posedge i_clk_sys) disable iff (!rst_n)
      burst_reg && burst_cnt_reg == BURST_LAST && !ncs_s |=> burst_cnt_reg == BURST_LAST;
   endproperty
   a_burst_sticks: assert property (p_burst_sticks) else $error("burst ran past pixel sum");

   property p_burst_end;
      @(posedge i_clk_sys) disable iff (!rst_n)
      ncs_s |=> !burst_reg && state_reg == ST_ADDR && !rd_pend_reg;
   endproperty
   a_burst_end: assert property (p_burst_end) else $error("chip select did not end burst");

   property p_soft_reset;
      @(posedge i_clk_sys) disable iff (!i_reset_n)
      wr_soft |=> o_chip_reset ##1 !o_chip_reset && !o_power_down && !o_burst_active;
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("soft reset not applied");

   property p_reserved_zero;
      @(posedge i_clk_sys) disable iff (!rst_n)
      push_fire && !burst_reg && !addr_mapped |-> push_if.data == 8'h00;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved read not zero");
endmodule

// ---- sim/msurb_spi_master.sv ----
`timescale 1ns/1ps
module msurb_spi_master (
   output logic o_sclk,
   output logic o_chip_select_n,
   output logic o_mosi,
   input wire logic i_miso
);
   initial
   begin
      o_sclk = 1'b1;
      o_chip_select_n = 1'b1;
      o_mosi = 1'b0;
   end
   task automatic start();
   begin
      o_chip_select_n = 1'b0;
      #64;
   end
   endtask
   // mode 3: drive on falling edge, sample just before the rising edge
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
   begin
      for (int i = 7; i >= 0; i--)
      begin
         o_sclk = 1'b0;
         o_mosi = tx[i];
         #32;
         rx[i] = i_miso;
         o_sclk = 1'b1;
         #32;
      end
      // sclk parked high between bytes so read data can be queued
      #64;
   end
   endtask
   task automatic stop();
   begin
      o_chip_select_n = 1'b1;
      o_mosi = ~o_mosi; // released line must not keep a stale value
      #200;
   end
   endtask
endmodule

// ---- sim/motion_sensor_upper_register_bank_bench.sv ----
`timescale 1ns/1ps
module motion_sensor_upper_register_bank_bench;
   import msurb_pkg::*;
   localparam logic [7:0] REV = 8'h3c; // arbitrary value
   logic i_clk_sys, i_reset_n, sclk, cs_n, mosi, miso, oe, frame;
   logic [7:0] index, dx, dy, squal, maxp, psum, minp, x;
   logic [15:0] shut;
   logic [1:0] rest_st, rest_f;
   logic pd, res, led, force_stb, creset, burst;
   int errors, num_checks, n_force, n_creset;
   wire [6:0] pix = index[6:0] ^ 7'h2a;
   msurb_spi_master m (.o_sclk(sclk), .o_chip_select_n(cs_n), .o_mosi(mosi), .i_miso(miso));
   msurb_top #(.REVISION_ID(REV), .FIFO_DEPTH(16)) dut (.i_clk_sys(i_clk_sys),
      .i_reset_n(i_reset_n), .i_sclk(sclk), .i_chip_select_n(cs_n), .i_mosi(mosi),
      .o_miso(miso), .o_miso_oe(oe), .i_frame_start(frame), .i_pixel_data(pix),
      .o_pixel_index(index), .i_delta_x(dx), .i_delta_y(dy), .i_squal(squal),
      .i_shutter(shut), .i_max_pixel(maxp), .i_pixel_sum(psum), .i_min_pixel(minp),
      .i_rest_mode_status(rest_st), .o_power_down(pd), .o_resolution_select(res),
      .o_led_current_select(led), .o_rest_mode_field(rest_f),
      .o_rest_force_strobe(force_stb), .o_chip_reset(creset), .o_burst_active(burst));
   initial
   begin
      i_clk_sys = 1'b0;
      forever #2.5 i_clk_sys = ~i_clk_sys;
   end
   always @(posedge i_clk_sys)
   begin
      if (force_stb === 1'b1) n_force <= n_force + 1;
      if (creset === 1'b1) n_creset <= n_creset + 1;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
   begin
      num_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
   begin
      m.start();
      m.xfer(a | 8'h80, x);
      m.xfer(d, x);
      m.stop();
   end
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
   begin
      m.start();
      m.xfer(a, x);
      m.xfer(8'h00, d);
      m.stop();
   end
   endtask
   task automatic frame_pulse();
   begin
      @(negedge i_clk_sys) frame = 1'b1;
      @(negedge i_clk_sys) frame = 1'b0;
   end
   endtask
   task automatic t_reset();
      logic [7:0] v;
   begin
      chk({pd, res, led, rest_f, burst}, 16'h0000);
      rd(8'h0d, v);
      chk(v, 16'h0000);
      @(negedge i_clk_sys) rest_st = 2'h2;
      rd(8'h45, v);
      chk(v, 16'h0080);
      rd(8'h3f, v);
      chk(v, {8'h00, ~REV});
      rd(8'h0a, v);
      chk(v, 16'h004d);
   end
   endtask
   task automatic t_ctrl();
      logic [7:0] v;
   begin
      wr(8'h0d, 8'hff);
      chk({pd, res}, 16'h0003);
      rd(8'h0d, v);
      chk(v, 16'h0003);
      wr(8'h0d, 8'h01);
      chk({pd, res}, 16'h0001);
      wr(8'h40, 8'hff);
      chk(led, 16'h0001);
      wr(8'h40, 8'hfe);
      chk(led, 16'h0000);
      wr(8'h0e, 8'hff);
      rd(8'h0e, v);
      chk(v, 16'h0000);
      chk({pd, res, led}, 16'h0002);
   end
   endtask
   task automatic t_rest();
   begin
      for (int i = 0; i < 4; i++)
      begin
         wr(8'h45, {i[1:0], 6'h3f});
         chk(rest_f, i[1:0]);
      end
      chk(n_force, 16'h0004);
   end
   endtask
   task automatic t_pixel();
      logic [7:0] v;
   begin
      wr(8'h0b, 8'ha5);
      chk(index, 16'h0000);
      rd(8'h0b, v);
      chk(v, 16'h0000);
      // a whole image: one valid read per pixel
      for (int k = 0; k < 225; k++)
      begin
         frame_pulse();
         if (k == 0) frame_pulse();
         rd(8'h0b, v);
         chk(v, {8'h00, 1'b1, k[6:0] ^ 7'h2a});
         chk(index, (k == 224) ? 16'h0000 : k[15:0] + 16'h0001);
         if (k == 0) rd(8'h0b, v);
         // flag drops after the read, the last intensity stays
         if (k == 0) chk(v, 16'h002a);
      end
      frame_pulse();
      rd(8'h0b, v);
      chk(v, 16'h00aa);
      frame_pulse();
      wr(8'h0b, 8'h5a);
      chk(index, 16'h0000);
      rd(8'h0b, v);
      chk(v, 16'h002b);
      frame_pulse();
      rd(8'h0b, v);
      chk(v, 16'h00aa);
   end
   endtask
   task automatic t_burst();
      logic [7:0] e [9] = '{8'h21, 8'h32, 8'h43, 8'h54, 8'h76, 8'h65, 8'h7a, 8'h7a, 8'h7a};
      logic [7:0] v;
   begin
      @(negedge i_clk_sys);
      {dx, dy, squal, shut, maxp, psum} = {8'h21, 8'h32, 8'h43, 16'h5476, 8'h65, 8'h7a};
      m.start();
      m.xfer(8'h63, v);
      chk({burst, oe}, 16'h0003);
      for (int i = 0; i < 9; i++)
      begin
         m.xfer(8'h00, v);
         chk(v, e[i]);
      end
      m.stop();
      chk(burst, 16'h0000);
      rd(8'h0d, v);
      chk(v, 16'h0001);
   end
   endtask
   task automatic t_soft();
      logic [7:0] v;
   begin
      wr(8'h0d, 8'h03);
      wr(8'h3a, 8'h12);
      chk({pd, n_creset[0]}, 16'h0002);
      wr(8'h3a, 8'h5a);
      chk({pd, res, rest_f, n_creset[7:0]}, 16'h0001);
      rd(8'h0d, v);
      chk(v, 16'h0000);
      // controller waits out the reset, then reloads its settings
      repeat (20) @(negedge i_clk_sys);
      wr(8'h0d, 8'h01);
      chk({pd, res}, 16'h0001);
   end
   endtask
   task automatic end_sim();
   begin
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   end
   endtask
   initial
   begin
      #450000;
      errors++;
      end_sim();
   end
   initial
   begin
      i_reset_n = 1'b0;
      frame = 1'b0;
      {dx, dy, squal, shut, maxp, psum} = '0;
      minp = 8'h4d;
      rest_st = 2'h0;
      repeat (10) @(negedge i_clk_sys);
      i_reset_n = 1'b1;
      repeat (8) @(negedge i_clk_sys);
      t_reset();
      t_ctrl();
      t_rest();
      t_pixel();
      t_burst();
      t_soft();
      end_sim();
   end
endmodule
